/* uisfc_regs.svh */
/*
 Register map, field positions, reset values and codes of the
 interrupt status and FIFO control block.
 Assumes inclusion by bare name from the core.
*/
`ifndef UISFC_REGS_SVH
`define UISFC_REGS_SVH

// Byte offsets on the AHB-Lite bus
`define UISFC_OFS_ISR 8'h00
`define UISFC_OFS_FCR 8'h04
`define UISFC_OFS_IER 8'h08
`define UISFC_OFS_CTL 8'h0C
`define UISFC_OFS_LVL 8'h10

// fifo_setup fields
`define UISFC_FCR_EN 0
`define UISFC_FCR_TX_LO 4
`define UISFC_FCR_RX_LO 6
`define UISFC_FCR_RST 8'h00

// Interrupt enable fields
`define UISFC_IER_RDA 0
`define UISFC_IER_THR 1
`define UISFC_IER_LS 2
`define UISFC_IER_MS 3
`define UISFC_IER_XOFF 5
`define UISFC_IER_RTS 6
`define UISFC_IER_CTS 7
`define UISFC_IER_RST 8'h00

// Control fields: 256-byte mode, enhanced feature enable, auto flow
`define UISFC_CTL_M256 0
`define UISFC_CTL_EFE 1
`define UISFC_CTL_AUTO 2
`define UISFC_CTL_RST 3'h0

// Identification codes, low six bits of the status byte
`define UISFC_ID_NONE 6'h01
`define UISFC_ID_LS 6'h06
`define UISFC_ID_RDA 6'h04
`define UISFC_ID_TO 6'h0C
`define UISFC_ID_THR 6'h02
`define UISFC_ID_MS 6'h00
`define UISFC_ID_XOFF 6'h10
`define UISFC_ID_RC 6'h20

// Trigger levels in characters
`define UISFC_RX_L0 8'h08
`define UISFC_RX_L1 8'h10
`define UISFC_RX_L2 8'h38
`define UISFC_RX_L3 8'h3C
`define UISFC_TX_L0 8'h08
`define UISFC_TX_L1 8'h10
`define UISFC_TX_L2 8'h20
`define UISFC_TX_L3 8'h38

`endif

/* uisfc_pkg.sv */
/*
 Types shared by the block: event inputs and level outputs.
 Assumes the register header sits in the same folder.
*/
package uisfc_pkg;
	// Pulses and levels from the neighbouring FIFO, shifter and register logic
	typedef struct packed {
		logic lineErr;
		logic rxTimeout;
		logic thrEmpty;
		logic modemChg;
		logic xoffDet;
		logic rtsRise;
		logic ctsRise;
		logic lsrRead;
		logic msrRead;
		logic rbrRead;
		logic thrWrite;
		logic txFull;
		logic rxFull;
		logic [7:0] rxLevel;
		logic [7:0] txLevel;
	} uisfc_evt_t;

	// Decoded setup handed to the FIFO and flow-control logic
	typedef struct packed {
		logic fifoEn;
		logic [7:0] rxTrig;
		logic [7:0] txTrig;
		logic [7:0] flowUpper;
	} uisfc_lvl_t;
endpackage

/* uisfc_core.sv */
/*
 Interrupt identification and FIFO setup decode for one UART
 channel, with an AHB-Lite register slave.
 Assumes event inputs come from logic on mclk, pulses one cycle wide.
*/
// Functional notes
// - Status low bits give only top pending code; 01 none, 06 line status.
// - With 256 mode off, status bits 7 and 6 mirror FIFO enable.
// - With 256 mode on, bit 7 is 0 when transmit FIFO full.
// - With 256 mode on, bit 6 is 1 when receive FIFO full.
// - Transmit count 00h: bit 7 high means empty, low means full.
// - Receive count 00h: bit 6 high means full, low means empty.
// - Code 04 at priority 2 when receive fill reaches trigger.
// - Receive-data interrupt follows the fill; it clears once the receive fill drops below trigger.
// - Code 0C at priority 2 on character timeout; buffer read clears.
// - Code 02 at priority 3 on transmit empty; status read or write clears.
// - Code 00 at priority 4 on modem input change; modem read clears.
// - Code 10 at priority 5 on Xoff or special character; status read clears.
// - Code 20 at priority 6 on RTS/CTS rise in auto flow; read clears.
// - Receive trigger from bits 7:6: 8, 16, 56, 60.
// - Flow upper threshold uses same encoding: 8, 16, 56, 60.
// - Transmit trigger from bits 5:4; 00 selects 8.
// - Transmit trigger field changes only with enhanced features enabled.
// - FIFO enable bit enables both FIFOs; cleared by default.
// - A source becomes pending only when its enable bit is set.
`timescale 1ns/1ns
`include "uisfc_regs.svh"

module uisfc_core (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire uisfc_pkg::uisfc_evt_t evt,
	output uisfc_pkg::uisfc_lvl_t lvl,
	output logic irq
);
	import uisfc_pkg::*;

	logic [7:0] fcr_r;
	logic [7:0] ier_r;
	logic [2:0] ctl_r;
	logic [31:0] rdata_r;
	logic wrPend_r;
	logic [7:0] wrAddr_r;
	logic lsP_r, rdaP_r, toP_r, thrP_r, msP_r, xoffP_r, rcP_r;
	logic txAbove_r;
	logic irq_r;
	uisfc_lvl_t lvl_r;

	// Address phase decode
	wire accept = hsel & hready & htrans[1];
	wire rdAcc = accept & ~hwrite;
	wire wrAcc = accept & hwrite;
	wire isrRd = rdAcc & (haddr == `UISFC_OFS_ISR);
	wire wrFcr = wrPend_r & (wrAddr_r == `UISFC_OFS_FCR);
	wire wrIer = wrPend_r & (wrAddr_r == `UISFC_OFS_IER);
	wire wrCtl = wrPend_r & (wrAddr_r == `UISFC_OFS_CTL);

	wire fifoEn = fcr_r[`UISFC_FCR_EN];
	wire m256 = ctl_r[`UISFC_CTL_M256];
	wire efe = ctl_r[`UISFC_CTL_EFE];
	wire autoFl = ctl_r[`UISFC_CTL_AUTO];

	// Trigger decode from the stored setup fields
	wire [1:0] rxSel = fcr_r[`UISFC_FCR_RX_LO +: 2];
	wire [1:0] txSel = fcr_r[`UISFC_FCR_TX_LO +: 2];
	wire [7:0] rxTrig = (rxSel == 2'h0) ? `UISFC_RX_L0 :
		(rxSel == 2'h1) ? `UISFC_RX_L1 :
		(rxSel == 2'h2) ? `UISFC_RX_L2 : `UISFC_RX_L3;
	wire [7:0] txTrig = (txSel == 2'h0) ? `UISFC_TX_L0 :
		(txSel == 2'h1) ? `UISFC_TX_L1 :
		(txSel == 2'h2) ? `UISFC_TX_L2 : `UISFC_TX_L3;

	// A full receive FIFO wraps its count to zero, so the full flag counts too
	wire rxAny = evt.rxFull | (evt.rxLevel != 8'h00);
	wire rxAtTrig = evt.rxFull | (evt.rxLevel >= rxTrig);
	wire txAbove = fifoEn & (evt.txLevel > txTrig);
	wire txCross = txAbove & ~txAbove_r;

	// Status bits 7 and 6
	wire bit7 = m256 ? ~evt.txFull : fifoEn;
	wire bit6 = m256 ? evt.rxFull : fifoEn;

	// Priority encoder: only the top pending source is shown
	wire [5:0] idCode = lsP_r ? `UISFC_ID_LS :
		rdaP_r ? `UISFC_ID_RDA :
		toP_r ? `UISFC_ID_TO :
		thrP_r ? `UISFC_ID_THR :
		msP_r ? `UISFC_ID_MS :
		xoffP_r ? `UISFC_ID_XOFF :
		rcP_r ? `UISFC_ID_RC : `UISFC_ID_NONE;
	wire [7:0] isrByte = {bit7, bit6, idCode};

	// A status read clears the source that it reports, and only for the transmit empty, Xoff and flow-pin codes
	wire isrClrThr = isrRd & (idCode == `UISFC_ID_THR);
	wire isrClrXoff = isrRd & (idCode == `UISFC_ID_XOFF);
	wire isrClrRc = isrRd & (idCode == `UISFC_ID_RC);

	// Set terms are gated by the enables so a masked source never latches
	wire lsSet = evt.lineErr & ier_r[`UISFC_IER_LS];
	wire rdaSet = rxAny & rxAtTrig & ier_r[`UISFC_IER_RDA];
	wire toSet = evt.rxTimeout & rxAny & ier_r[`UISFC_IER_RDA];
	wire thrSet = (evt.thrEmpty | txCross) & ier_r[`UISFC_IER_THR];
	wire msSet = evt.modemChg & ier_r[`UISFC_IER_MS];
	wire xoffSet = evt.xoffDet & efe & ier_r[`UISFC_IER_XOFF];
	wire rcSet = autoFl & efe & ((evt.rtsRise & ier_r[`UISFC_IER_RTS]) |
		(evt.ctsRise & ier_r[`UISFC_IER_CTS]));

	// Read data mux; unmapped and write-only locations read as zero
	wire [31:0] rdMux = (haddr == `UISFC_OFS_ISR) ? {24'h000000, isrByte} :
		(haddr == `UISFC_OFS_IER) ? {24'h000000, ier_r} :
		(haddr == `UISFC_OFS_CTL) ? {29'h0, ctl_r} :
		(haddr == `UISFC_OFS_LVL) ? {14'h0, evt.rxFull, evt.txFull, evt.txLevel, evt.rxLevel} :
		32'h00000000;

	// Transmit field keeps its value unless enhanced features are on
	wire [1:0] txSelNxt = efe ? hwdata[`UISFC_FCR_TX_LO +: 2] : txSel;
	wire [7:0] fcr_nxt = {hwdata[7:6], txSelNxt, 3'h0, hwdata[`UISFC_FCR_EN]};

	// Bus slave: zero wait states, so the address is latched for the data phase
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wrPend_r <= 1'b0;
			wrAddr_r <= 8'h00;
			rdata_r <= 32'h00000000;
		end else begin
			wrPend_r <= wrAcc;
			wrAddr_r <= haddr;
			rdata_r <= rdAcc ? rdMux : 32'h00000000;
		end
	end

	// Software-written setup
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fcr_r <= `UISFC_FCR_RST;
			ier_r <= `UISFC_IER_RST;
			ctl_r <= `UISFC_CTL_RST;
		end else begin
			if (wrFcr) fcr_r <= fcr_nxt;
			if (wrIer) ier_r <= hwdata[7:0];
			if (wrCtl) ctl_r <= hwdata[2:0];
		end
	end

	// Pending flags: a set in the clearing cycle wins
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			lsP_r <= 1'b0;
			rdaP_r <= 1'b0;
			toP_r <= 1'b0;
			thrP_r <= 1'b0;
			msP_r <= 1'b0;
			xoffP_r <= 1'b0;
			rcP_r <= 1'b0;
			txAbove_r <= 1'b0;
		end else begin
			lsP_r <= lsSet | (lsP_r & ~evt.lsrRead);
			rdaP_r <= rdaSet;
			toP_r <= toSet | (toP_r & ~evt.rbrRead);
			thrP_r <= thrSet | (thrP_r & ~isrClrThr & ~evt.thrWrite);
			msP_r <= msSet | (msP_r & ~evt.msrRead);
			xoffP_r <= xoffSet | (xoffP_r & ~isrClrXoff);
			rcP_r <= rcSet | (rcP_r & ~isrClrRc);
			txAbove_r <= txAbove;
		end
	end

	// Registered outputs: interrupt line and decoded levels
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_r <= 1'b0;
			lvl_r <= '0;
		end else begin
			irq_r <= (idCode != `UISFC_ID_NONE);
			lvl_r <= '{fifoEn: fifoEn, rxTrig: rxTrig, txTrig: txTrig, flowUpper: rxTrig};
		end
	end

	assign hrdata = rdata_r;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign irq = irq_r;
	assign lvl = lvl_r;

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// With every enable clear, an idle status must stay idle whatever events arrive
	a_none_when_masked: assert property ((ier_r == 8'h00) && (idCode == `UISFC_ID_NONE) |=>
		(idCode == `UISFC_ID_NONE)) else $error("interrupt became pending with all enables clear");
	a_ls_top_code: assert property (lsP_r |-> idCode == `UISFC_ID_LS)
		else $error("line status not at top priority");
	a_bit7_mirror: assert property (!m256 |-> (bit7 == fifoEn) && (bit6 == fifoEn))
		else $error("status bits 7 and 6 do not mirror fifo enable");
	a_bit7_txfull: assert property (m256 && evt.txLevel == 8'h00 |-> bit7 == !evt.txFull)
		else $error("bit 7 wrong for transmit full state");
	a_bit6_rxfull: assert property (m256 && evt.rxLevel == 8'h00 |-> bit6 == evt.rxFull)
		else $error("bit 6 wrong for receive full state");
	a_rda_raise: assert property (rdaSet |=> rdaP_r ##0 (lsP_r || idCode == `UISFC_ID_RDA))
		else $error("receive data interrupt not raised");
	a_rda_clear: assert property (!rxAtTrig |=> !rdaP_r)
		else $error("receive data interrupt held below trigger");
	a_timeout_clear: assert property (evt.rbrRead && !toSet |=> !toP_r)
		else $error("timeout not cleared by buffer read");
	a_thr_clear: assert property (evt.thrWrite && !thrSet |=> !thrP_r)
		else $error("transmit empty not cleared by write");
	a_modem_hold: assert property (msP_r && !evt.msrRead |=> msP_r)
		else $error("modem interrupt lost without a read");
	a_xoff_read: assert property (isrRd && idCode == `UISFC_ID_XOFF && !xoffSet |=> !xoffP_r)
		else $error("xoff interrupt not cleared by status read");
	a_rc_gate: assert property (!autoFl && !rcP_r |=> !rcP_r)
		else $error("flow pin interrupt outside auto flow");
	a_trig_decode: assert property (rxSel == 2'h2 |=> lvl_r.rxTrig == 8'h38 && lvl_r.flowUpper == 8'h38)
		else $error("receive trigger decode wrong");
	a_tx_decode: assert property (txSel == 2'h2 |=> lvl_r.txTrig == 8'h20)
		else $error("transmit trigger decode wrong");
	a_tx_locked: assert property (wrFcr && !efe |=> $stable(txSel))
		else $error("transmit trigger changed with features off");
	a_fifo_enable: assert property (wrFcr |=> ##1 lvl_r.fifoEn == $past(hwdata[0], 2))
		else $error("fifo enable not taken");
	a_irq_follow: assert property ((idCode != `UISFC_ID_NONE) |=> irq_r)
		else $error("interrupt output not asserted while pending");

	c_ls_then_rda: cover property (lsP_r && rdaP_r ##1 evt.lsrRead ##1 idCode == `UISFC_ID_RDA);
	c_thr_isr_read: cover property (isrClrThr);
	c_tx_locked_write: cover property (wrFcr && !efe);
	c_rx_full_256: cover property (m256 && evt.rxFull && bit6);
endmodule

/* uisfc_host.sv */
/*
 Host model: AHB-Lite master doing single word transfers.
 Assumes one slave whose hreadyout is fed back as hready.
*/
`timescale 1ns/1ns
module uisfc_host (
	input wire logic mclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [7:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	output logic hung
);
	// Idle bus at time zero
	initial begin
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		hung = 1'b0;
	end

	// Bounded wait, so a stuck slave flags a hang instead of freezing
	task automatic waitReady();
		int n;
		n = 0;
		@(posedge mclk);
		while (hready !== 1'b1 && n < 64) begin
			n++;
			@(posedge mclk);
		end
		if (hready !== 1'b1) hung <= 1'b1;
	endtask

	// Address phase, then data phase; read data taken at the closing edge
	task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		waitReady();
		htrans <= 2'h0;
		hwdata <= wd;
		waitReady();
		rd = hrdata;
	endtask
endmodule

/* test_uart_interrupt_status_fifo_control.sv */
/*
 Testbench: register and event sequences with expected values.
 Assumes the core answers with zero wait states.
*/
`timescale 1ns/1ns
module test_uart_interrupt_status_fifo_control;
	import uisfc_pkg::*;
	logic mclk, rstN, hsel, hwrite, hreadyout, hresp, irq, hung;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata;
	uisfc_evt_t evt;
	uisfc_lvl_t lvl;
	int fails, checks;
	logic [7:0] rxTab [4] = '{8'h08, 8'h10, 8'h38, 8'h3C};
	logic [7:0] txTab [4] = '{8'h08, 8'h10, 8'h20, 8'h38};

	uisfc_core u_uisfc_core (.mclk(mclk), .rst_n(rstN), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .evt(evt), .lvl(lvl), .irq(irq));
	uisfc_host u_uisfc_host (.mclk(mclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hung(hung));

	always #5 mclk = ~mclk;

	task automatic report_and_stop();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		u_uisfc_host.xfer(a, 1'b0, 32'h0, d);
		check(d, exp);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] d;
		u_uisfc_host.xfer(a, 1'b1, wd, d);
	endtask

	// Pulse bits run lineErr (400) down to thrWrite (001); settle two edges
	task automatic fire(input logic [10:0] m);
		evt[28:18] <= m;
		@(posedge mclk);
		evt[28:18] <= 11'h000;
		repeat (2) @(posedge mclk);
	endtask

	// Bus hang or overall run limit ends in the same report
	always @(posedge mclk) begin
		if (hung === 1'b1) begin
			fails++;
			report_and_stop();
		end
	end
	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		report_and_stop();
	end

	initial begin
		mclk = 1'b0;
		rstN = 1'b0;
		evt = '0;
		fails = 0;
		checks = 0;
		repeat (5) @(posedge mclk);
		rstN <= 1'b1;
		@(posedge mclk);
		rd(8'h00, 32'h01);
		check(32'(lvl), {7'h0, 1'b0, 8'h08, 8'h08, 8'h08});
		rd(8'h04, 32'h0);
		rd(8'h20, 32'h0);
		check(32'(hresp), 32'h0);
		check(32'(hreadyout), 32'h1);
		fire(11'h400);
		check(32'(irq), 32'h0);
		rd(8'h00, 32'h01);
		$display("test defaults done");
		// Every trigger code, with enhanced features on so tx field moves
		wr(8'h0C, 32'h2);
		for (int i = 0; i < 4; i++) begin
			wr(8'h04, {24'h0, 2'(i), 2'(i), 4'h1});
			repeat (2) @(posedge mclk);
			check(32'(lvl), {7'h0, 1'b1, rxTab[i], txTab[i], rxTab[i]});
			rd(8'h00, 32'hC1);
		end
		wr(8'h0C, 32'h0);
		wr(8'h04, 32'h11);
		repeat (2) @(posedge mclk);
		check(32'(lvl), {7'h0, 1'b1, 8'h08, 8'h38, 8'h08});
		$display("test triggers done");
		// Every source but receive data at once (fill 1 is below trigger 8), then clear one by one in priority order
		wr(8'h08, 32'hFF);
		wr(8'h0C, 32'h7);
		evt.rxLevel <= 8'h01;
		fire(11'h7E0);
		check(32'(irq), 32'h1);
		rd(8'h00, 32'h86);
		fire(11'h008);
		rd(8'h00, 32'h8C);
		fire(11'h002);
		rd(8'h00, 32'h82);
		rd(8'h00, 32'h80);
		fire(11'h004);
		rd(8'h00, 32'h90);
		rd(8'h00, 32'hA0);
		fire(11'h010);
		rd(8'h00, 32'hA0);
		rd(8'h00, 32'h81);
		check(32'(irq), 32'h0);
		$display("test priority done");
		// Both counts at 00h with both FIFOs full; a full receive FIFO is past any trigger
		evt[17:0] <= {2'b11, 16'h0000};
		@(posedge mclk);
		rd(8'h00, 32'h44);
		// Receive fill at trigger, then one below
		evt[17:0] <= {2'b00, 8'h08, 8'h00};
		repeat (2) @(posedge mclk);
		rd(8'h00, 32'h84);
		evt.rxLevel <= 8'h07;
		repeat (2) @(posedge mclk);
		rd(8'h00, 32'h81);
		$display("test levels done");
		report_and_stop();
	end
endmodule
